// [common/srw_pkg.sv]
package srw_pkg;

    // block clock
    localparam int CLK_PERIOD_NS = 100;

    // reset hold interval (least time, rounds up)
    localparam longint RESET_HOLD_MS = 140;
    localparam longint RESET_HOLD_CYCLES =
        (RESET_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // watchdog period, nominal
    localparam longint WATCHDOG_PERIOD_MS = 1600;
    localparam longint WATCHDOG_PERIOD_CYCLES = (WATCHDOG_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

    // open-input pull split: low for 7/8, high for the last 1/8
    localparam int PULL_LOW_NUM = 7;
    localparam int PULL_DEN = 8;

    // cycles after a pull flip during which the pin is allowed to follow our own pull
    localparam logic [31:0] PULL_SETTLE_CYCLES = 32'h0000_0004;

    // manual reset debounce: input must stay stable this long
    localparam int DEBOUNCE_NS = 1000;
    localparam logic [15:0] DEBOUNCE_CYCLES = 16'((DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // counter width for the long timers
    localparam int TIMER_W = 32;

    // reset-time values and the counter step
    localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;
    localparam logic [31:0] COUNT_ONE = 32'h0000_0001;
    localparam logic [15:0] DEB_ZERO = 16'h0000;

    // internal state seen from outside, for observation
    typedef struct packed {
        logic hold_active;
        logic wd_fault;
        logic strobe_open;
    } srw_status_t;

endpackage

// [rtl/srw_debounce.sv]
// two-flop synchroniser followed by a stability filter for a pushbutton input
module srw_debounce (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic raw_in,
    output logic clean_out
);

    logic meta_reg;
    logic sync_reg;
    logic [15:0] stable_cnt_reg;

    // first flop is read only by the second
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end
        else
        begin
            meta_reg <= raw_in;
            sync_reg <= meta_reg;
        end
    end

    // output follows only after the input held its new level long enough;
    // bounce restarts the count, so chatter never reaches the reset logic
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            stable_cnt_reg <= srw_pkg::DEB_ZERO;
            clean_out <= 1'b1;
        end
        else if (sync_reg == clean_out)
        begin
            stable_cnt_reg <= srw_pkg::DEB_ZERO;
        end
        else if (stable_cnt_reg == srw_pkg::DEBOUNCE_CYCLES - 16'h0001)
        begin
            stable_cnt_reg <= srw_pkg::DEB_ZERO;
            clean_out <= sync_reg;
        end
        else
        begin
            stable_cnt_reg <= stable_cnt_reg + 16'h0001;
        end
    end

endmodule

// [rtl/srw_top.sv]
module srw_top #(
    parameter logic [31:0] RESET_HOLD_CYCLES = 32'(srw_pkg::RESET_HOLD_CYCLES),
    parameter logic [31:0] WATCHDOG_PERIOD_CYCLES = 32'(srw_pkg::WATCHDOG_PERIOD_CYCLES),
    parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic supply_low,
    input wire logic manual_reset_request_n,
    input wire logic watchdog_strobe_in,
    output logic watchdog_strobe_pull_out,
    output logic watchdog_strobe_pull_oe,
    output logic reset_out,
    output logic watchdog_fault_out_n,
    output srw_pkg::srw_status_t status_out
);

    // end of the low pull phase within a period
    localparam logic [31:0] PULL_LOW_CYCLES =
        32'((64'(WATCHDOG_PERIOD_CYCLES) * srw_pkg::PULL_LOW_NUM) / srw_pkg::PULL_DEN);

    // asynchronous pins: index 0 supply comparator, index 1 strobe
    logic [1:0] async_in;
    logic [1:0] meta_reg;
    logic [1:0] sync_reg;
    logic supply_low_s;
    logic strobe_s;
    logic manual_clean;
    logic reset_src;
    logic hold_active_reg;
    logic [31:0] hold_cnt_reg;
    logic [31:0] pull_cnt_reg;
    logic pull_high;
    logic in_settle;
    logic low_seen_reg;
    logic open_reg;
    logic strobe_prev_reg;
    logic strobe_edge;
    logic valid_edge;
    logic [31:0] wd_cnt_reg;
    logic wd_fault_reg;

    assign async_in = {watchdog_strobe_in, supply_low};

    // two flops per pin; the first is read by nothing else
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (!rst_b)
                begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end
                else
                begin
                    meta_reg[i] <= async_in[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign supply_low_s = sync_reg[0];
    assign strobe_s = sync_reg[1];

    srw_debounce u_manual_debounce (
        .clk(clk),
        .rst_b(rst_b),
        .raw_in(manual_reset_request_n),
        .clean_out(manual_clean)
    );

    assign reset_src = supply_low_s | ~manual_clean;

    // hold stretcher: counter is held at zero while any source is active, so the
    // interval is measured from the moment the last source goes away
    // power-up hold
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            hold_active_reg <= 1'b1;
            hold_cnt_reg <= srw_pkg::COUNT_ZERO;
        end
        else if (reset_src)
        begin
            hold_active_reg <= 1'b1;
            hold_cnt_reg <= srw_pkg::COUNT_ZERO;
        end
        else if (hold_active_reg)
        begin
            if (hold_cnt_reg == RESET_HOLD_CYCLES - srw_pkg::COUNT_ONE)
            begin
                hold_active_reg <= 1'b0;
                hold_cnt_reg <= srw_pkg::COUNT_ZERO;
            end
            else
            begin
                hold_cnt_reg <= hold_cnt_reg + srw_pkg::COUNT_ONE;
            end
        end
    end

    // polarity chosen at build time, one flop either way
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            reset_out <= RESET_ACTIVE_HIGH;
        end
        else
        begin
            reset_out <= RESET_ACTIVE_HIGH ? hold_active_reg : ~hold_active_reg;
        end
    end

    // free-running pull phase counter, one lap per watchdog period
    // repeats every period
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pull_cnt_reg <= srw_pkg::COUNT_ZERO;
        end
        else if (pull_cnt_reg == WATCHDOG_PERIOD_CYCLES - srw_pkg::COUNT_ONE)
        begin
            pull_cnt_reg <= srw_pkg::COUNT_ZERO;
        end
        else
        begin
            pull_cnt_reg <= pull_cnt_reg + srw_pkg::COUNT_ONE;
        end
    end

    // low for 7/8, high for the last 1/8
    assign pull_high = (pull_cnt_reg >= PULL_LOW_CYCLES);

    // edges right after our own pull flips are the pin echoing us, not the host
    assign in_settle = (pull_cnt_reg < srw_pkg::PULL_SETTLE_CYCLES) ||
        (pull_high && (pull_cnt_reg < PULL_LOW_CYCLES + srw_pkg::PULL_SETTLE_CYCLES));

    // the pull is weak: an outside driver overrides it on the wire
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            watchdog_strobe_pull_out <= 1'b0;
            watchdog_strobe_pull_oe <= 1'b0;
        end
        else
        begin
            watchdog_strobe_pull_out <= pull_high;
            watchdog_strobe_pull_oe <= 1'b1;
        end
    end

    // strobe edge detect on the synchronised level
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            strobe_prev_reg <= 1'b0;
        end
        else
        begin
            strobe_prev_reg <= strobe_s;
        end
    end

    assign strobe_edge = strobe_s ^ strobe_prev_reg;
    // while judged open, only edges outside the echo window count
    assign valid_edge = strobe_edge & ~(open_reg & in_settle);

    // open detection: pin low at the end of the low phase and high at the end of
    // the high phase means nobody drives it; a real edge overrides, so the host wins a tie
    // detect open input
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            low_seen_reg <= 1'b0;
            open_reg <= 1'b0;
        end
        else
        begin
            if (pull_cnt_reg == PULL_LOW_CYCLES - srw_pkg::COUNT_ONE)
            begin
                low_seen_reg <= ~strobe_s;
            end
            if (valid_edge && !in_settle)
            begin
                open_reg <= 1'b0;
            end
            else if (pull_cnt_reg == WATCHDOG_PERIOD_CYCLES - srw_pkg::COUNT_ONE)
            begin
                open_reg <= low_seen_reg & strobe_s;
            end
        end
    end

    // watchdog timer; the fault stays until the next strobe edge or until the pin is judged open
    // held while reset is active
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wd_cnt_reg <= srw_pkg::COUNT_ZERO;
            wd_fault_reg <= 1'b0;
        end
        else if (hold_active_reg || open_reg || valid_edge)
        begin
            wd_cnt_reg <= srw_pkg::COUNT_ZERO;
            wd_fault_reg <= 1'b0;
        end
        else if (!wd_fault_reg)
        begin
            if (wd_cnt_reg == WATCHDOG_PERIOD_CYCLES - srw_pkg::COUNT_ONE)
            begin
                wd_fault_reg <= 1'b1;
                wd_cnt_reg <= srw_pkg::COUNT_ZERO;
            end
            else
            begin
                wd_cnt_reg <= wd_cnt_reg + srw_pkg::COUNT_ONE;
            end
        end
    end

    // brownout forces the fault output low
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            watchdog_fault_out_n <= 1'b1;
        end
        else
        begin
            watchdog_fault_out_n <= ~(wd_fault_reg | supply_low_s);
        end
    end

    // observation bundle
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            status_out <= '{hold_active: 1'b1, wd_fault: 1'b0, strobe_open: 1'b0};
        end
        else
        begin
            status_out <= '{hold_active: hold_active_reg, wd_fault: wd_fault_reg, strobe_open: open_reg};
        end
    end

endmodule

// [sim/srw_host_model.sv]
// host side: strobes the watchdog pin or leaves it floating
module srw_host_model (
    input wire logic clk,
    input wire logic drive_en,
    input wire logic kick,
    input wire logic pull_out,
    input wire logic pull_oe,
    output logic strobe_wire
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] hi_cnt = 2'h0;
    logic float_pat = 1'b0;
    always @(posedge clk)
    begin
        hi_cnt <= kick ? 2'h3 : (hi_cnt == 2'h0 ? 2'h0 : hi_cnt - 2'h1);
        float_pat <= ~float_pat;
    end
    // weak pull loses to the host; a bare pin wanders so no value is trusted
    assign strobe_wire = drive_en ? (hi_cnt != 2'h0) : (pull_oe ? pull_out : float_pat);
endmodule

// [sim/srw_top_sva.sv]
module srw_top_sva #(
    parameter logic [31:0] RESET_HOLD_CYCLES = 32'h32,
    parameter logic [31:0] WATCHDOG_PERIOD_CYCLES = 32'ha0,
    parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic supply_low,
    input wire logic manual_reset_request_n,
    input wire logic watchdog_strobe_in,
    input wire logic watchdog_strobe_pull_out,
    input wire logic watchdog_strobe_pull_oe,
    input wire logic reset_out,
    input wire logic watchdog_fault_out_n,
    input wire srw_pkg::srw_status_t status_out
);
    logic act;
    logic strobe_q;
    logic seen_hi;
    logic [31:0] quiet;
    logic [31:0] idle;
    logic [31:0] low_n;
    // reset asserted, whatever the polarity
    assign act = (reset_out == RESET_ACTIVE_HIGH);
    // quiet: no source; idle: no edge while counting; low_n: pull low run
    always_ff @(posedge clk)
    begin
        strobe_q <= watchdog_strobe_in;
        quiet <= (!rst_b || supply_low || !manual_reset_request_n) ? 32'h0 : quiet + 32'h1;
        idle <= (act || status_out.strobe_open || watchdog_strobe_in != strobe_q) ? 32'h0 : idle + 32'h1;
        low_n <= (watchdog_strobe_pull_oe && !watchdog_strobe_pull_out) ? low_n + 32'h1 : 32'h0;
        seen_hi <= rst_b && (seen_hi || watchdog_strobe_pull_out);
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_supply_reset: assert property (supply_low [*5] |-> act)
        else $error("reset missing on low supply");
    a_supply_fault: assert property (supply_low [*5] |-> !watchdog_fault_out_n)
        else $error("fault missing on low supply");
    a_manual_reset: assert property ((!manual_reset_request_n) [*8] ##1 (!manual_reset_request_n) [*8] |-> act)
        else $error("reset missing on manual press");
    a_hold_min: assert property (act ##1 !act |-> quiet >= RESET_HOLD_CYCLES)
        else $error("reset released too early");
    a_hold_max: assert property (quiet == RESET_HOLD_CYCLES + 32'h14 |-> !act)
        else $error("reset held too long");
    a_wd_early: assert property ($fell(watchdog_fault_out_n) && quiet > 32'h8 |->
        idle >= WATCHDOG_PERIOD_CYCLES - 32'h4)
        else $error("fault before period ran out");
    a_wd_late: assert property (idle == WATCHDOG_PERIOD_CYCLES + 32'h8 |-> !watchdog_fault_out_n)
        else $error("fault missing after period");
    a_pull_split: assert property ($rose(watchdog_strobe_pull_out) && seen_hi |->
        low_n == (WATCHDOG_PERIOD_CYCLES / 32'h8) * 32'h7)
        else $error("pull low phase wrong length");
    a_pull_held: assert property ($past(rst_b) |-> watchdog_strobe_pull_oe)
        else $error("pull released after reset");
endmodule
bind srw_top srw_top_sva #(
    .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES),
    .WATCHDOG_PERIOD_CYCLES(WATCHDOG_PERIOD_CYCLES),
    .RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH)
) i_srw_top_sva (
    .clk(clk),
    .rst_b(rst_b),
    .supply_low(supply_low),
    .manual_reset_request_n(manual_reset_request_n),
    .watchdog_strobe_in(watchdog_strobe_in),
    .watchdog_strobe_pull_out(watchdog_strobe_pull_out),
    .watchdog_strobe_pull_oe(watchdog_strobe_pull_oe),
    .reset_out(reset_out),
    .watchdog_fault_out_n(watchdog_fault_out_n),
    .status_out(status_out)
);

// [sim/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = 50;
    localparam int WD = 160;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic supply_low = 1'b0;
    logic press = 1'b0;
    logic drive_en = 1'b1;
    logic kick = 1'b0;
    logic strobe;
    logic pull_out;
    logic pull_oe;
    logic reset_out;
    logic reset_hi;
    logic fault_n;
    srw_pkg::srw_status_t status;
    int num_errors = 0;
    int check_count = 0;
    // 100 ns period
    always #50 clk = ~clk;
    srw_top #(
        .RESET_HOLD_CYCLES(32'(HOLD)),
        .WATCHDOG_PERIOD_CYCLES(32'(WD)),
        .RESET_ACTIVE_HIGH(1'b0)
    ) i_srw_top (
        .clk(clk),
        .rst_b(rst_b),
        .supply_low(supply_low),
        .manual_reset_request_n(~press),
        .watchdog_strobe_in(strobe),
        .watchdog_strobe_pull_out(pull_out),
        .watchdog_strobe_pull_oe(pull_oe),
        .reset_out(reset_out),
        .watchdog_fault_out_n(fault_n),
        .status_out(status)
    );
    srw_host_model i_srw_host_model (
        .clk(clk),
        .drive_en(drive_en),
        .kick(kick),
        .pull_out(pull_out),
        .pull_oe(pull_oe),
        .strobe_wire(strobe)
    );
    // active-high build on the same inputs
    srw_top #(
        .RESET_HOLD_CYCLES(32'(HOLD)),
        .WATCHDOG_PERIOD_CYCLES(32'(WD)),
        .RESET_ACTIVE_HIGH(1'b1)
    ) i_srw_top_hi (
        .clk(clk),
        .rst_b(rst_b),
        .supply_low(supply_low),
        .manual_reset_request_n(~press),
        .watchdog_strobe_in(strobe),
        .watchdog_strobe_pull_out(),
        .watchdog_strobe_pull_oe(),
        .reset_out(reset_hi),
        .watchdog_fault_out_n(),
        .status_out()
    );
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic pulse_kick;
        @(posedge clk) kick <= 1'b1;
        @(posedge clk) kick <= 1'b0;
        #1;
    endtask
    task automatic t_power;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        step(HOLD - 2);
        chk(reset_out, 1'b0);
        chk(reset_hi, 1'b1);
        chk(status.hold_active, 1'b1);
        step(10);
        chk(reset_out, 1'b1);
        chk(reset_hi, 1'b0);
        step(WD - 20);
        chk(fault_n, 1'b1);
        step(30);
        chk(fault_n, 1'b0);
        chk(status.wd_fault, 1'b1);
        $display("power test done");
    endtask
    task automatic t_kick;
        pulse_kick();
        step(8);
        chk(fault_n, 1'b1);
        // kicks land some 40 cycles inside the period
        repeat (3)
        begin
            step(WD - 40);
            pulse_kick();
            chk(fault_n, 1'b1);
        end
        step(WD - 12);
        chk(fault_n, 1'b1);
        step(24);
        chk(fault_n, 1'b0);
        $display("watchdog test done");
    endtask
    task automatic t_supply;
        @(posedge clk) supply_low <= 1'b1;
        step(6);
        chk(reset_out, 1'b0);
        chk(reset_hi, 1'b1);
        pulse_kick();
        step(6);
        chk(fault_n, 1'b0);
        @(posedge clk) supply_low <= 1'b0;
        step(HOLD);
        chk(reset_out, 1'b0);
        step(12);
        chk(reset_out, 1'b1);
        $display("supply test done");
    endtask
    task automatic t_manual;
        @(posedge clk) press <= 1'b1;
        step(5);
        @(posedge clk) press <= 1'b0;
        step(20);
        chk(reset_out, 1'b1);
        @(posedge clk) press <= 1'b1;
        step(HOLD + 20);
        chk(reset_out, 1'b0);
        @(posedge clk) press <= 1'b0;
        step(HOLD);
        chk(reset_out, 1'b0);
        step(24);
        chk(reset_out, 1'b1);
        $display("manual test done");
    endtask
    task automatic t_open;
        pulse_kick();
        @(posedge clk) drive_en <= 1'b0;
        step(3 * WD);
        chk(status.strobe_open, 1'b1);
        step(WD);
        chk(status.strobe_open, 1'b1);
        chk(fault_n, 1'b1);
        @(posedge clk) drive_en <= 1'b1;
        step(2 * WD + 10);
        chk(status.strobe_open, 1'b0);
        $display("open test done");
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        t_power();
        t_kick();
        t_supply();
        t_manual();
        t_open();
        results();
    end
    // tests need about 2000 cycles; allow two and a half times
    initial
    begin
        #500000;
        num_errors++;
        results();
    end
endmodule
